// file: shared/acs_pkg.sv
// constants, encodings and state type of the conversion sequencer
// assumes the sequencer clock is the converter system clock at CLK_HZ
package acs_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RESET_TIME_NS = 50_000;
  localparam int unsigned RESET_CYCLES = (RESET_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DIV_NORMAL = 16;
  localparam int unsigned DIV_TURBO = 8;
  localparam int unsigned START_DLY_NORMAL = 210;
  localparam int unsigned START_DLY_TURBO = 114;
  localparam int unsigned DUTY_IDLE_PERIODS = 3;

  // conversion length in modulator ticks, from the normal-mode rate span
  localparam int unsigned MOD_HZ_NORMAL = 256_000;
  localparam int unsigned RATE_MIN_SPS = 20;
  localparam int unsigned RATE_MAX_SPS = 1000;
  localparam int unsigned CONV_TICKS_MAX = MOD_HZ_NORMAL / RATE_MIN_SPS;
  localparam int unsigned CONV_TICKS_MIN = MOD_HZ_NORMAL / RATE_MAX_SPS;

  // widths and buffer depth
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned TEMP_W = 14;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned TICK_W = 16;

  // command bytes, bit 0 is a don't-care
  localparam logic [7:0] CMD_MASK = 8'hFE;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // operating mode field
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_DUTY = 2'h1;
  localparam logic [1:0] OPM_TURBO = 2'h2;

  // configuration defaults
  localparam logic DEF_CONV_MODE = 1'b0;
  localparam logic [2:0] DEF_RATE = 3'h0;
  localparam logic [1:0] DEF_OPM = OPM_NORMAL;
  localparam logic DEF_TEMP_SEL = 1'b0;
  localparam logic DEF_RDY_DOUT = 1'b0;
  localparam logic DEF_PSW = 1'b0;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_START_DLY,
    ST_CONVERT,
    ST_STORE,
    ST_DUTY_IDLE,
    ST_LOW_POWER,
    ST_SLEEP
  } acs_state_e;

endpackage : acs_pkg

// file: verilog/acs_fifo.sv
// result buffer: synchronous fifo with registered read data
// assumes one clock; the head word is valid whenever out_valid is high
`timescale 1ns/1ps
`default_nettype none

module acs_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } acs_fifo_s;

  acs_fifo_s s;
  acs_fifo_s next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid && s.in_ready;
  assign pop = out_ready && s.out_valid;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr_ptr = (s.wr_ptr == LAST) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == LAST) ? '0 : s.rd_ptr + 1'b1;
    end
    next_s.count = s.count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_s.in_ready = (next_s.count != FULL);
    next_s.out_valid = (next_s.count != '0);
    // bypass covers the word written this cycle at the new head
    if (push && (s.wr_ptr == next_s.rd_ptr)) begin
      next_s.out_data = in_data;
    end else begin
      next_s.out_data = mem[next_s.rd_ptr];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0,
             out_data: '0};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wr_ptr] <= in_data;
    end
  end

  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = s.out_data;

endmodule : acs_fifo

`default_nettype wire

// file: verilog/acs_sequencer.sv
// conversion sequencer: power-up reset, conversion and operating modes, mode-1 serial port
// assumes serial pins are already synchronous to clk and sampled once per clock;
// the analog front end supplies sample_in and temp_in, valid whenever they are taken
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] temperature is 14 bits left-aligned, twos complement
// [R2] power-up reset runs about 50 us
// [R3] reset loads defaults, single-shot selected
// [R4] first conversion after reset, ready falls
// [R5] conversion mode bit picks single or continuous
// [R6] single-shot converts once per start, then low power
// [R7] single-shot config write restarts one conversion
// [R8] continuous stores result, starts next at once
// [R9] continuous needs mode bit and start, delayed
// [R10] continuous config write restarts current conversion
// [R11] host sends start right after setting mode
// [R12] normal mode default, modulator clock divide 16
// [R13] rate field sets conversion length, scales
// [R14] duty-cycle idles three periods after each conversion
// [R15] duty-cycle rates quarter of normal rates
// [R16] turbo mode modulator clock divide 8
// [R17] sleep finishes conversion, powers down, opens switch
// [R18] start in sleep wakes per mode bit
// [R19] config write in sleep wakes single conversion
// [R20] serial port is mode 1 only
// [R21] ready can also show on serial output
// [R22] host holds chip select low per transaction
// [R23] chip select high resets port, floats output
// [R24] host keeps serial clock low when idle
// [R25] ready returns high on next clock rise
// [R26] start command byte is 0000 100x
// [R27] sleep command byte is 0000 001x
// [R28] input data sampled on falling clock edges
// [R29] last result stays readable during low power
module acs_sequencer #(
  parameter int unsigned RESET_CYCLES = acs_pkg::RESET_CYCLES,
  parameter int unsigned CONV_TICKS_MAX = acs_pkg::CONV_TICKS_MAX,
  parameter int unsigned CONV_TICKS_MIN = acs_pkg::CONV_TICKS_MIN,
  parameter int unsigned FIFO_DEPTH = acs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic serial_out_with_ready,
  output logic serial_out_oe_n,
  output logic result_ready_n,
  // configuration write
  input wire logic cfg_write,
  input wire logic cfg_conversion_mode_bit,
  input wire logic [2:0] cfg_rate_select_field,
  input wire logic [1:0] cfg_op_mode,
  input wire logic cfg_temp_sel,
  input wire logic cfg_ready_on_dout,
  input wire logic cfg_switch_enable,
  // analog front end
  input wire logic [acs_pkg::RESULT_W-1:0] sample_in,
  input wire logic [acs_pkg::TEMP_W-1:0] temp_in,
  output logic analog_on,
  output logic low_side_switch_closed,
  output logic sleeping
);

  typedef struct packed {
    acs_pkg::acs_state_e state;
    logic [acs_pkg::CNT_W-1:0] cnt;
    logic [4:0] div_cnt;
    logic [acs_pkg::TICK_W-1:0] tick_cnt;
    logic [1:0] idle_per;
    logic conversion_mode_bit;
    logic [2:0] rate_select_field;
    logic [1:0] op_mode;
    logic temp_sel;
    logic ready_on_dout;
    logic switch_enable;
    logic cont_run;
    logic sleep_pend;
    logic switch_closed;
    logic analog_on;
    logic asleep;
    logic [acs_pkg::RESULT_W-1:0] last_result;
    logic result_ready_n;
    logic sclk_prev;
    logic [7:0] in_shift;
    logic [2:0] in_cnt;
    logic [acs_pkg::RESULT_W-1:0] out_shift;
    logic tx_started;
    logic dout;
    logic dout_oe_n;
  } acs_seq_s;

  localparam logic [acs_pkg::CNT_W-1:0] RST_LAST = acs_pkg::CNT_W'(RESET_CYCLES - 1);
  localparam logic [acs_pkg::CNT_W-1:0] DLY_N_LAST = acs_pkg::CNT_W'(acs_pkg::START_DLY_NORMAL - 1);
  localparam logic [acs_pkg::CNT_W-1:0] DLY_T_LAST = acs_pkg::CNT_W'(acs_pkg::START_DLY_TURBO - 1);
  localparam logic [4:0] DIV_N_LAST = 5'(acs_pkg::DIV_NORMAL - 1);
  localparam logic [4:0] DIV_T_LAST = 5'(acs_pkg::DIV_TURBO - 1);
  localparam logic [1:0] IDLE_LAST = 2'(acs_pkg::DUTY_IDLE_PERIODS - 1);
  localparam logic [acs_pkg::TICK_W-1:0] TICKS_MAX = acs_pkg::TICK_W'(CONV_TICKS_MAX);
  localparam logic [acs_pkg::TICK_W-1:0] TICKS_MIN = acs_pkg::TICK_W'(CONV_TICKS_MIN);

  acs_seq_s s;
  acs_seq_s next_s;

  // result buffer
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [acs_pkg::RESULT_W-1:0] fifo_out_data;
  logic [acs_pkg::RESULT_W-1:0] store_word;

  // serial events
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] cmd_byte;
  logic byte_done;
  logic start_cmd;
  logic sleep_cmd;
  logic live;
  logic tick;
  logic [4:0] div_last;
  logic [acs_pkg::CNT_W-1:0] dly_last;
  logic [acs_pkg::TICK_W-1:0] conv_last;
  logic [acs_pkg::TICK_W-1:0] ticks;
  logic [acs_pkg::RESULT_W-1:0] load_word;

  ////////////////////////////////////////////////////////////////////////////////

  // conversion results stall in ST_STORE while the buffer is full
  acs_fifo #(
    .WIDTH(acs_pkg::RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(store_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // chip select high masks both clock edges
  assign sclk_rise = !cs_n && sclk && !s.sclk_prev; // [R20] [R23]
  assign sclk_fall = !cs_n && !sclk && s.sclk_prev; // [R20] [R28]
  assign cmd_byte = {s.in_shift[6:0], din}; // [R28]
  assign byte_done = sclk_fall && (s.in_cnt == acs_pkg::BIT_LAST);
  assign live = (s.state != acs_pkg::ST_RESET);
  assign start_cmd = live && byte_done
      && ((cmd_byte & acs_pkg::CMD_MASK) == acs_pkg::CMD_START); // [R26]
  assign sleep_cmd = live && byte_done
      && ((cmd_byte & acs_pkg::CMD_MASK) == acs_pkg::CMD_SLEEP); // [R27]

  // temperature code lands in the top 14 bits, sign bit unchanged
  assign store_word = s.temp_sel ? {temp_in, 2'b00} : sample_in; // [R1]
  assign fifo_in_valid = (s.state == acs_pkg::ST_STORE);
  assign fifo_pop = sclk_rise && !s.tx_started && fifo_out_valid;
  // an empty buffer still answers with the last stored result
  assign load_word = fifo_out_valid ? fifo_out_data : s.last_result; // [R29]

  assign div_last = (s.op_mode == acs_pkg::OPM_TURBO) ? DIV_T_LAST : DIV_N_LAST; // [R12] [R16]
  assign tick = (s.div_cnt == div_last);
  assign dly_last = (s.op_mode == acs_pkg::OPM_TURBO) ? DLY_T_LAST : DLY_N_LAST; // [R9]
  // halving per rate code, floored at the fastest rate
  assign ticks = TICKS_MAX >> s.rate_select_field; // [R13]
  assign conv_last = ((ticks < TICKS_MIN) ? TICKS_MIN : ticks) - 1'b1; // [R13]

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.sclk_prev = sclk;
    next_s.div_cnt = tick ? '0 : s.div_cnt + 1'b1;

    // sequencer
    case (s.state)
      acs_pkg::ST_RESET: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == RST_LAST) begin // [R2]
          next_s.state = acs_pkg::ST_CONVERT; // [R4]
          next_s.tick_cnt = '0;
          next_s.div_cnt = '0;
        end
      end
      acs_pkg::ST_START_DLY: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == dly_last) begin // [R9]
          next_s.state = acs_pkg::ST_CONVERT;
          next_s.tick_cnt = '0;
          next_s.div_cnt = '0;
        end
      end
      acs_pkg::ST_CONVERT: begin
        if (tick) begin
          next_s.tick_cnt = s.tick_cnt + 1'b1;
          if (s.tick_cnt == conv_last) begin
            next_s.state = acs_pkg::ST_STORE;
          end
        end
      end
      acs_pkg::ST_STORE: begin
        if (fifo_in_ready) begin
          next_s.last_result = store_word; // [R29]
          if (s.sleep_pend) begin
            next_s.state = acs_pkg::ST_SLEEP; // [R17]
            next_s.sleep_pend = 1'b0;
          end else if (!s.cont_run) begin
            next_s.state = acs_pkg::ST_LOW_POWER; // [R4] [R6]
          end else if (s.op_mode == acs_pkg::OPM_DUTY) begin
            next_s.state = acs_pkg::ST_DUTY_IDLE; // [R14] [R15]
            next_s.idle_per = '0;
            next_s.tick_cnt = '0;
          end else begin
            next_s.state = acs_pkg::ST_CONVERT; // [R8]
            next_s.tick_cnt = '0;
          end
        end
      end
      acs_pkg::ST_DUTY_IDLE: begin
        // three idle periods of one conversion length each
        if (tick) begin
          next_s.tick_cnt = s.tick_cnt + 1'b1;
          if (s.tick_cnt == conv_last) begin
            next_s.tick_cnt = '0;
            next_s.idle_per = s.idle_per + 1'b1;
            if (s.idle_per == IDLE_LAST) begin
              next_s.state = acs_pkg::ST_CONVERT; // [R14]
            end
          end
        end
      end
      acs_pkg::ST_LOW_POWER, acs_pkg::ST_SLEEP: begin
      end
      default: begin
        next_s.state = acs_pkg::ST_LOW_POWER;
      end
    endcase

    // commands and configuration writes override the sequence
    if (start_cmd) begin
      next_s.cont_run = s.conversion_mode_bit; // [R5] [R9] [R18]
      next_s.sleep_pend = 1'b0;
      next_s.state = acs_pkg::ST_START_DLY; // [R6] [R18]
      next_s.cnt = '0;
      next_s.switch_closed = s.switch_enable;
    end else if (live && cfg_write) begin
      next_s.conversion_mode_bit = cfg_conversion_mode_bit;
      next_s.rate_select_field = cfg_rate_select_field;
      next_s.op_mode = cfg_op_mode;
      next_s.temp_sel = cfg_temp_sel;
      next_s.ready_on_dout = cfg_ready_on_dout;
      next_s.switch_enable = cfg_switch_enable;
      if (s.state == acs_pkg::ST_SLEEP) begin
        next_s.cont_run = 1'b0; // [R19]
        next_s.state = acs_pkg::ST_START_DLY; // [R19]
        next_s.cnt = '0;
      end else if (!s.cont_run) begin
        next_s.state = acs_pkg::ST_START_DLY; // [R7]
        next_s.cnt = '0;
      end else if (s.state == acs_pkg::ST_CONVERT) begin
        next_s.tick_cnt = '0; // [R10]
        next_s.div_cnt = '0;
      end
    end
    if (sleep_cmd) begin
      // a store landing this cycle has already finished its conversion
      if ((s.state == acs_pkg::ST_CONVERT)
          || ((s.state == acs_pkg::ST_STORE) && !fifo_in_ready)) begin
        next_s.sleep_pend = 1'b1; // [R17]
      end else begin
        next_s.state = acs_pkg::ST_SLEEP; // [R17]
      end
    end
    if (!next_s.switch_enable || (next_s.state == acs_pkg::ST_SLEEP)) begin
      next_s.switch_closed = 1'b0; // [R17]
    end
    // oscillator and analog blocks only run while a conversion is pending
    next_s.analog_on = (next_s.state == acs_pkg::ST_START_DLY)
        || (next_s.state == acs_pkg::ST_CONVERT)
        || (next_s.state == acs_pkg::ST_STORE); // [R6] [R14] [R17]
    next_s.asleep = (next_s.state == acs_pkg::ST_SLEEP); // [R17]

    // serial port
    if (cs_n) begin
      next_s.in_cnt = '0; // [R23]
      next_s.in_shift = '0;
      next_s.tx_started = 1'b0;
      next_s.out_shift = '0;
    end else if (sclk_fall) begin
      next_s.in_shift = cmd_byte; // [R28]
      next_s.in_cnt = s.in_cnt + 1'b1;
    end
    if (sclk_rise) begin
      next_s.result_ready_n = 1'b1; // [R25]
      if (!s.tx_started) begin
        next_s.tx_started = 1'b1;
        next_s.dout = load_word[acs_pkg::RESULT_W-1]; // [R20]
        next_s.out_shift = {load_word[acs_pkg::RESULT_W-2:0], 1'b0};
      end else begin
        next_s.dout = s.out_shift[acs_pkg::RESULT_W-1]; // [R20]
        next_s.out_shift = {s.out_shift[acs_pkg::RESULT_W-2:0], 1'b0};
      end
    end
    // a finished conversion wins over a clock edge in the same cycle
    if ((s.state == acs_pkg::ST_STORE) && fifo_in_ready) begin
      next_s.result_ready_n = 1'b0; // [R4] [R8]
    end
    if (!cs_n && !next_s.tx_started && s.ready_on_dout) begin
      next_s.dout = next_s.result_ready_n; // [R21]
    end
    if (cs_n) begin
      next_s.dout = 1'b0;
    end
    next_s.dout_oe_n = cs_n; // [R23]
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{state: acs_pkg::ST_RESET, cnt: '0, div_cnt: '0, tick_cnt: '0, idle_per: '0,
             conversion_mode_bit: acs_pkg::DEF_CONV_MODE, // [R3]
             rate_select_field: acs_pkg::DEF_RATE,
             op_mode: acs_pkg::DEF_OPM, // [R12]
             temp_sel: acs_pkg::DEF_TEMP_SEL,
             ready_on_dout: acs_pkg::DEF_RDY_DOUT,
             switch_enable: acs_pkg::DEF_PSW, asleep: 1'b0,
             cont_run: 1'b0, sleep_pend: 1'b0, switch_closed: 1'b0, analog_on: 1'b1,
             last_result: '0, result_ready_n: 1'b1, sclk_prev: 1'b0, in_shift: '0,
             in_cnt: '0, out_shift: '0, tx_started: 1'b0, dout: 1'b0, dout_oe_n: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign serial_out_with_ready = s.dout;
  assign serial_out_oe_n = s.dout_oe_n;
  assign result_ready_n = s.result_ready_n;
  assign analog_on = s.analog_on;
  assign low_side_switch_closed = s.switch_closed;
  assign sleeping = s.asleep;

endmodule : acs_sequencer

`default_nettype wire

// file: tb/acs_sequencer_checker.sv
// assertions on the sequencer pins: serial port, ready line, power states
// assumes it is bound into acs_sequencer, which hands on RESET_CYCLES
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_checker #(
  parameter int unsigned RESET_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out_with_ready,
  input wire logic serial_out_oe_n,
  input wire logic result_ready_n,
  // power state
  input wire logic analog_on,
  input wire logic low_side_switch_closed,
  input wire logic sleeping
);
  logic [15:0] since_rst;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // saturates so a long run never wraps back into the reset window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_rst <= 16'h0000;
    end else if (since_rst != 16'hFFFF) begin
      since_rst <= since_rst + 16'h0001;
    end
  end

  a_reset_quiet: assert property (
    since_rst < RESET_CYCLES |-> result_ready_n && !sleeping)
    else $error("ready or sleep during power-up reset");
  a_oe_tracks_cs: assert property (
    1'b1 |-> serial_out_oe_n == $past(cs_n))
    else $error("output enable does not follow chip select");
  a_dout_idle_zero: assert property (
    $past(cs_n) |-> !serial_out_with_ready)
    else $error("serial out active while deselected");
  // a store in the same cycle may keep the line low, only while converting
  a_ready_clears: assert property (
    $rose(sclk) && !cs_n && !result_ready_n |=> result_ready_n || $past(analog_on))
    else $error("ready not cleared by serial clock rise");
  a_ready_after_conv: assert property (
    $fell(result_ready_n) |-> $past(analog_on))
    else $error("ready fell without a conversion");
  a_start_hold: assert property (
    $rose(analog_on) |-> analog_on [*8])
    else $error("conversion ended too early");
  a_sleep_off: assert property (
    sleeping && $past(sleeping) |-> !analog_on && !low_side_switch_closed)
    else $error("analog or switch active in power-down");
  a_sleep_no_result: assert property (
    sleeping && $past(sleeping) |-> !$fell(result_ready_n))
    else $error("result produced in power-down");
endmodule : acs_sequencer_checker

bind acs_sequencer acs_sequencer_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
  .clk, .rst, .cs_n, .sclk, .serial_out_with_ready, .serial_out_oe_n,
  .result_ready_n, .analog_on, .low_side_switch_closed, .sleeping
);
`default_nettype wire

// file: tb/acs_host.sv
// host controller model: mode-1 serial frames, msb first
// assumes clk is the sequencer clock; lines change on its falling edge
`timescale 1ns/1ps
`default_nettype none

module acs_host (
  // clock
  input wire logic clk,
  // serial lines
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // one frame of n bits; four clocks per clock phase keeps every phase settled
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    // line level before the first clock; shifted out again by a full read
    rx[0] = dout;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      din = tx[i];
      repeat (4) @(negedge clk);
      rx = {rx[14:0], dout};
      sclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    din = ~din; // released line must not show a stale value
  endtask : xfer
endmodule : acs_host
`default_nettype wire

// file: tb/acs_sequencer_tb.sv
// testbench of the conversion sequencer: commands, reads and timing windows
// assumes acs_host drives the serial pins and the checker is bound by its file
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_tb;
  localparam int RST_CYC = 20;
  localparam int TICKS = 8;
  localparam int NORM = acs_pkg::START_DLY_NORMAL + TICKS * acs_pkg::DIV_NORMAL;
  localparam int TURBO = acs_pkg::START_DLY_TURBO + TICKS * acs_pkg::DIV_TURBO;
  localparam int DUTY = acs_pkg::DUTY_IDLE_PERIODS * TICKS * acs_pkg::DIV_NORMAL;
  localparam int RATE1 = acs_pkg::START_DLY_NORMAL + TICKS / 2 * acs_pkg::DIV_NORMAL;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, din, serial_out_with_ready, serial_out_oe_n, result_ready_n;
  logic cfg_write = 1'b0;
  logic cfg_conversion_mode_bit = 1'b0;
  logic [2:0] cfg_rate_select_field = 3'h0;
  logic [1:0] cfg_op_mode = 2'h0;
  logic cfg_temp_sel = 1'b0;
  logic cfg_ready_on_dout = 1'b0;
  logic cfg_switch_enable = 1'b1;
  logic [15:0] sample_in = 16'hA5C3;
  logic [13:0] temp_in = 14'h3CE0;
  logic analog_on, low_side_switch_closed, sleeping;
  logic [15:0] rx;
  int errors = 0;
  int checks_done = 0;
  int n;
  wire dout_line = serial_out_oe_n ? 1'bz : serial_out_with_ready;

  always #2.5 clk = ~clk;

  acs_sequencer #(.RESET_CYCLES(RST_CYC), .CONV_TICKS_MAX(TICKS), .CONV_TICKS_MIN(2),
    .FIFO_DEPTH(acs_pkg::FIFO_DEPTH)) u_dut (
    .clk, .rst, .cs_n, .sclk, .din, .serial_out_with_ready, .serial_out_oe_n,
    .result_ready_n, .cfg_write, .cfg_conversion_mode_bit, .cfg_rate_select_field,
    .cfg_op_mode, .cfg_temp_sel, .cfg_ready_on_dout, .cfg_switch_enable,
    .sample_in, .temp_in, .analog_on, .low_side_switch_closed, .sleeping
  );
  acs_host u_host (.clk, .cs_n, .sclk, .din, .dout(dout_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cfg(input logic mode, input logic [1:0] opm, input logic tsel);
    @(negedge clk);
    cfg_conversion_mode_bit = mode;
    cfg_op_mode = opm;
    cfg_temp_sel = tsel;
    cfg_write = 1'b1;
    @(negedge clk);
    cfg_write = 1'b0;
  endtask : cfg
  task automatic cmd(input logic [7:0] b);
    u_host.xfer({8'h00, b}, 8, rx);
  endtask : cmd
  task automatic read_chk(input logic [15:0] exp);
    u_host.xfer(16'h0000, 16, rx);
    check(rx, exp);
  endtask : read_chk
  // bounded, so a missing result shows up as a failed window, not a hang
  task automatic wait_rdy(output int cnt);
    cnt = 0;
    while (result_ready_n !== 1'b0 && cnt < 3000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 3000) errors++;
  endtask : wait_rdy
  function automatic logic near(input int v, input int t);
    return v >= t - 12 && v <= t + 8;
  endfunction : near
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    wait_rdy(n);
    check(n > RST_CYC, 1'b1);
    repeat (4) @(negedge clk);
    check(analog_on, 1'b0);
    read_chk(16'hA5C3);
    check(result_ready_n, 1'b1);
    $display("test power-up done");
    cfg(1'b0, acs_pkg::OPM_NORMAL, 1'b1);
    wait_rdy(n);
    read_chk(16'hF380);
    cmd(8'h09);
    check(low_side_switch_closed, 1'b1);
    repeat (100) @(negedge clk);
    cfg(1'b0, acs_pkg::OPM_NORMAL, 1'b1);
    wait_rdy(n);
    check(near(n, NORM), 1'b1);
    read_chk(16'hF380);
    read_chk(16'hF380);
    cmd(8'h08);
    wait_rdy(n);
    check(near(n, NORM), 1'b1);
    check(analog_on, 1'b0);
    read_chk(16'hF380);
    $display("test single-shot done");
    cfg_rate_select_field = 3'h1;
    cfg_ready_on_dout = 1'b1;
    cfg_switch_enable = 1'b0;
    cfg(1'b0, acs_pkg::OPM_NORMAL, 1'b1);
    check(low_side_switch_closed, 1'b0);
    wait_rdy(n);
    check(near(n, RATE1), 1'b1);
    u_host.xfer(16'h0000, 0, rx);
    check(rx, 16'h0000);
    read_chk(16'hF380);
    u_host.xfer(16'h0000, 0, rx);
    check(rx, 16'h0001);
    cfg_rate_select_field = 3'h0;
    cfg_ready_on_dout = 1'b0;
    cfg_switch_enable = 1'b1;
    $display("test rate and ready line done");
    cfg(1'b0, acs_pkg::OPM_TURBO, 1'b0);
    wait_rdy(n);
    read_chk(16'hA5C3);
    cmd(8'h08);
    wait_rdy(n);
    check(near(n, TURBO), 1'b1);
    read_chk(16'hA5C3);
    $display("test turbo done");
    cmd(8'h03);
    repeat (4) @(negedge clk);
    check(sleeping, 1'b1);
    check(low_side_switch_closed, 1'b0);
    repeat (400) @(negedge clk);
    check(result_ready_n, 1'b1);
    cmd(8'h08);
    wait_rdy(n);
    check(sleeping, 1'b0);
    read_chk(16'hA5C3);
    cmd(8'h03);
    repeat (4) @(negedge clk);
    cfg(1'b1, acs_pkg::OPM_NORMAL, 1'b0);
    wait_rdy(n);
    read_chk(16'hA5C3);
    repeat (600) @(negedge clk);
    check(result_ready_n, 1'b1);
    check(analog_on, 1'b0);
    $display("test power-down done");
    cmd(8'h08);
    wait_rdy(n);
    check(near(n, NORM), 1'b1);
    check(analog_on, 1'b1);
    read_chk(16'hA5C3);
    wait_rdy(n);
    check(n <= TICKS * acs_pkg::DIV_NORMAL, 1'b1);
    cmd(8'h03);
    n = 0;
    while (sleeping !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(sleeping, 1'b1);
    read_chk(16'hA5C3);
    $display("test continuous done");
    cfg(1'b1, acs_pkg::OPM_DUTY, 1'b0);
    wait_rdy(n);
    read_chk(16'hA5C3);
    cmd(8'h08);
    wait_rdy(n);
    repeat (2) @(negedge clk);
    n = 2;
    while (analog_on !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(near(n, DUTY), 1'b1);
    $display("test duty-cycle done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule : acs_sequencer_tb
`default_nettype wire
